// *** verilog/etds_top.sv ***
// Purpose: builds the transmit descriptor status word per frame attempt
// Assumes: transmit engine events are synchronous to mclk
// Notes: one write-back pulse per attempt that ends, retries stay inside
`timescale 1ns/1ps
module etds_top #(
   parameter int XS_LIMIT_100 = etds_pkg::XS_DEFER_CYC_100,
   parameter int XS_LIMIT_10 = etds_pkg::XS_DEFER_CYC_10
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // Line speed, high for 100 Mbit/s
   input wire logic speed_100,
   // Transmit engine events
   input etds_pkg::etds_tx_ev_t tx_ev,
   // Descriptor write-back
   output logic desc_wr_valid,
   output etds_pkg::etds_status_t desc_wr_word,
   output logic descriptor_owner_flag,
   // Abandon request back to the transmit engine
   output logic tx_abandon,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Interrupt
   output logic irq
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_REPORT = 2'b10
   } etds_state_t;

   etds_state_t state_reg;
   etds_state_t state_next;
   etds_pkg::etds_status_t flags_reg;
   logic [15:0] byte_cnt_reg;
   logic [15:0] tl_reg;
   logic [1:0] ctrl_reg;
   logic [15:0] max_frame_length_field;
   logic [5:0] collision_window_config;
   logic [3:0] retry_limit_config;
   // Width first, the two registers below are sized by it
   localparam int IRQ_W_L = etds_pkg::IRQ_W;
   logic [IRQ_W_L-1:0] irq_stat_reg;
   logic [IRQ_W_L-1:0] irq_mask_reg;

   logic active;
   logic col_late;
   logic col_limit;
   logic col_retry;
   logic starve_abandon;
   logic starve_retry;
   logic abandon;
   logic restart;
   logic fcs_ok;
   logic xs_defer;
   logic [3:0] tally_inc;
   logic auto_fcs;
   logic report;
   etds_pkg::etds_status_t final_word;

   ////////////////////////////////////////////////////////////////////////////
   // Helper modules
   etds_fcs_check u_fcs (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .restart(restart),
      .byte_valid(active && tx_ev.byte_valid),
      .byte_data(tx_ev.byte_data),
      .fcs_ok(fcs_ok)
   );

   etds_defer_timer #(
      .LIMIT_100(XS_LIMIT_100),
      .LIMIT_10(XS_LIMIT_10)
   ) u_defer (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .restart(tx_ev.start),
      .deferring(active && tx_ev.deferring),
      .speed_100(speed_100),
      .excess(xs_defer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Attempt events
   assign active = (state_reg == ST_ACTIVE);
   assign auto_fcs = ctrl_reg[etds_pkg::CTRL_AUTO_FCS];
   // Tally saturates at its field width
   assign tally_inc = (flags_reg.collision_tally == 4'hf) ? 4'hf :
                      flags_reg.collision_tally + 4'h1;
   // Late: byte count already past the collision window
   assign col_late = active && tx_ev.collision &&
                     (byte_cnt_reg > {10'h000, collision_window_config});
   // Too many collisions for the retry limit
   assign col_limit = active && tx_ev.collision && !col_late &&
                      (tally_inc > retry_limit_config);
   // Early collision inside the window is retried while the tally stays within the retry limit
   assign col_retry = active && tx_ev.collision && !col_late && !col_limit;
   // Underrun outcome depends on the retry control bit
   assign starve_retry = active && tx_ev.underrun &&
                         ctrl_reg[etds_pkg::CTRL_UNDERRUN_RETRY];
   assign starve_abandon = active && tx_ev.underrun &&
                           !ctrl_reg[etds_pkg::CTRL_UNDERRUN_RETRY];
   // Late collisions are not retried since the frame is already on the wire
   assign abandon = col_late || col_limit || starve_abandon;
   // Restart rewinds count, type/length field and CRC only
   assign restart = tx_ev.start || col_retry || starve_retry;
   assign report = active && (abandon || tx_ev.finish);
   assign tx_abandon = active && abandon;

   ////////////////////////////////////////////////////////////////////////////
   // Attempt state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (tx_ev.start) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (report) begin
               state_next = ST_REPORT;
            end
         end
         ST_REPORT: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State holds while ce is low
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte counter, cleared on every new try
   // Saturates so a runaway frame stays oversize
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         byte_cnt_reg <= 16'h0000;
      end else if (ce) begin
         if (restart) begin
            byte_cnt_reg <= 16'h0000;
         end else if (active && tx_ev.byte_valid && byte_cnt_reg != 16'hffff) begin
            byte_cnt_reg <= byte_cnt_reg + 16'h0001;
         end
      end
   end

   // Type/length field capture, high byte first
   // A new try forgets the field, so a short try reads no stale value
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tl_reg <= 16'h0000;
      end else if (ce) begin
         if (restart) begin
            tl_reg <= 16'h0000;
         end else if (active && tx_ev.byte_valid) begin
            if (byte_cnt_reg == etds_pkg::TL_HI_POS) begin
               tl_reg[15:8] <= tx_ev.byte_data;
            end else if (byte_cnt_reg == etds_pkg::TL_LO_POS) begin
               tl_reg[7:0] <= tx_ev.byte_data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky per-attempt flags, cleared only at frame start
   // A retry keeps them: the word covers the whole attempt
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_reg <= '0;
      end else if (ce) begin
         if (tx_ev.start) begin
            flags_reg <= '0;
            flags_reg.descriptor_owner_flag <= 1'b1;
         end else if (active) begin
            if (tx_ev.backpressure) begin
               flags_reg.backpressure_applied_flag <= 1'b1;
            end
            if (tx_ev.deferring) begin
               flags_reg.deferred_flag <= 1'b1;
            end
            if (tx_ev.underrun) begin
               flags_reg.tx_buffer_starved_flag <= 1'b1;
            end
            if (tx_ev.collision) begin
               flags_reg.collision_tally <= tally_inc;
            end
            if (col_late) begin
               flags_reg.late_collision_flag <= 1'b1;
            end
            if (col_limit) begin
               flags_reg.retry_limit_flag <= 1'b1;
            end
            if (abandon) begin
               flags_reg.frame_abandoned_flag <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Final word: frame checks folded in at the end of the attempt
   always_comb begin
      final_word = flags_reg;
      final_word.frame_abandoned_flag = flags_reg.frame_abandoned_flag || abandon;
      final_word.tx_buffer_starved_flag = flags_reg.tx_buffer_starved_flag ||
                                          tx_ev.underrun;
      final_word.late_collision_flag = flags_reg.late_collision_flag || col_late;
      final_word.retry_limit_flag = flags_reg.retry_limit_flag || col_limit;
      if (tx_ev.collision) begin
         final_word.collision_tally = tally_inc;
      end
      final_word.deferred_flag = flags_reg.deferred_flag || tx_ev.deferring;
      final_word.backpressure_applied_flag = flags_reg.backpressure_applied_flag ||
                                             tx_ev.backpressure;
      final_word.excess_deferral_flag = xs_defer;
      final_word.oversize_frame_flag = (byte_cnt_reg > max_frame_length_field);
      final_word.length_out_of_range_flag = (tl_reg > etds_pkg::TL_MAX_LEN) &&
                                            (tl_reg < etds_pkg::TL_TYPE_MIN);
      // Only a length field is compared; type values are skipped
      final_word.length_mismatch_flag = (tl_reg < etds_pkg::TL_TYPE_MIN) &&
         (byte_cnt_reg >= etds_pkg::HDR_FCS_BYTES) &&
         (tl_reg != byte_cnt_reg - etds_pkg::HDR_FCS_BYTES);
      // With auto append on the FCS is ours, so it is never checked
      final_word.bad_fcs_flag = !auto_fcs && !fcs_ok;
      final_word.descriptor_owner_flag = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write-back: one pulse with the full word, ownership back to host
   // The word holds until the next report for the last-status read
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         desc_wr_valid <= 1'b0;
         desc_wr_word <= '0;
      end else if (ce) begin
         desc_wr_valid <= report;
         if (report) begin
            desc_wr_word <= final_word;
         end
      end
   end

   // Ownership level as seen by the host side
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         descriptor_owner_flag <= 1'b0;
      end else if (ce) begin
         if (tx_ev.start) begin
            descriptor_owner_flag <= 1'b1;
         end else if (report) begin
            descriptor_owner_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   // Unmapped indices are ignored
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= etds_pkg::CTRL_RESET;
         max_frame_length_field <= etds_pkg::MAX_FRAME_LENGTH_FIELD_RESET;
         collision_window_config <= etds_pkg::COLWIN_RESET;
         retry_limit_config <= etds_pkg::RETRY_RESET;
         irq_mask_reg <= '0;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            etds_pkg::REG_CTRL: ctrl_reg <= reg_wdata[1:0];
            etds_pkg::REG_MAX_FRAME_LENGTH_FIELD: max_frame_length_field <= reg_wdata;
            etds_pkg::REG_COLWIN: collision_window_config <= reg_wdata[5:0];
            etds_pkg::REG_RETRY: retry_limit_config <= reg_wdata[3:0];
            etds_pkg::REG_IRQ_MASK: irq_mask_reg <= reg_wdata[IRQ_W_L-1:0];
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over the clear that a read makes
   logic [IRQ_W_L-1:0] irq_set;
   logic irq_rd_clr;

   // Same bit order as the mask register
   assign irq_set = {report && tx_ev.underrun,
                     report && abandon,
                     report};
   assign irq_rd_clr = reg_rd && (reg_addr == etds_pkg::REG_IRQ_STAT);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_reg <= '0;
      end else if (ce) begin
         irq_stat_reg <= (irq_rd_clr ? '0 : irq_stat_reg) | irq_set;
      end
   end

   // Level straight from registers, no pulse to miss
   assign irq = |(irq_stat_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data stands in the cycle after the strobe only
   // Zero outside that cycle keeps a shared bus quiet
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         reg_rdata <= 16'h0000;
         if (reg_rd) begin
            case (reg_addr)
               etds_pkg::REG_CTRL: reg_rdata <= {14'h0000, ctrl_reg};
               etds_pkg::REG_MAX_FRAME_LENGTH_FIELD: reg_rdata <= max_frame_length_field;
               etds_pkg::REG_COLWIN: reg_rdata <= {10'h000, collision_window_config};
               etds_pkg::REG_RETRY: reg_rdata <= {12'h000, retry_limit_config};
               etds_pkg::REG_LAST: reg_rdata <= desc_wr_word;
               etds_pkg::REG_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_reg};
               etds_pkg::REG_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_reg};
               default: reg_rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule : etds_top

// *** verilog/etds_pkg.sv ***
// Purpose: constants and types for the transmit descriptor status block
// Assumes: 50 MHz mclk, one status word written back per frame attempt
// Notes: register offsets are word indices on the plain register port
package etds_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Status word layout
   typedef struct packed {
      logic descriptor_owner_flag;
      logic frame_abandoned_flag;
      logic backpressure_applied_flag;
      logic oversize_frame_flag;
      logic length_out_of_range_flag;
      logic length_mismatch_flag;
      logic bad_fcs_flag;
      logic deferred_flag;
      logic excess_deferral_flag;
      logic tx_buffer_starved_flag;
      logic late_collision_flag;
      logic retry_limit_flag;
      logic [3:0] collision_tally;
   } etds_status_t;

   // Per-cycle events from the transmit engine
   typedef struct packed {
      logic start;
      logic finish;
      logic byte_valid;
      logic [7:0] byte_data;
      logic collision;
      logic deferring;
      logic backpressure;
      logic underrun;
   } etds_tx_ev_t;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (word index)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_MAX_FRAME_LENGTH_FIELD = 4'h1;
   localparam logic [3:0] REG_COLWIN = 4'h2;
   localparam logic [3:0] REG_RETRY = 4'h3;
   localparam logic [3:0] REG_LAST = 4'h4;
   localparam logic [3:0] REG_IRQ_STAT = 4'h5;
   localparam logic [3:0] REG_IRQ_MASK = 4'h6;

   // Control bit positions
   localparam int CTRL_AUTO_FCS = 0;
   localparam int CTRL_UNDERRUN_RETRY = 1;

   // Reset values
   localparam logic [15:0] MAX_FRAME_LENGTH_FIELD_RESET = 16'h0600;
   localparam logic [5:0] COLWIN_RESET = 6'h37;
   localparam logic [3:0] RETRY_RESET = 4'hf;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   // Interrupt bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ABANDON = 1;
   localparam int IRQ_STARVED = 2;
   localparam int IRQ_W = 3;

   // Frame field positions and limits
   localparam logic [15:0] TL_HI_POS = 16'h000c;
   localparam logic [15:0] TL_LO_POS = 16'h000d;
   localparam logic [15:0] HDR_FCS_BYTES = 16'h0012;
   localparam logic [15:0] TL_MAX_LEN = 16'h05ee;
   localparam logic [15:0] TL_TYPE_MIN = 16'h0600;

   // Excessive deferral timing
   localparam int CLK_MHZ = 50;
   localparam int XS_DEFER_NIBBLES = 6071;
   localparam int NIBBLE_NS_100 = 40;
   localparam int XS_DEFER_BITS = 24287;
   localparam int BIT_NS_10 = 100;
   localparam int XS_DEFER_CYC_100 = XS_DEFER_NIBBLES * NIBBLE_NS_100 * CLK_MHZ / 1000;
   localparam int XS_DEFER_CYC_10 = XS_DEFER_BITS * BIT_NS_10 * CLK_MHZ / 1000;

   // FCS engine constants
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
endpackage : etds_pkg

// *** verilog/etds_fcs_check.sv ***
// Purpose: running CRC-32 over the frame bytes with residue check
// Assumes: bytes arrive LSB first order as on the wire
// Notes: fcs_ok is valid once the last FCS byte has been taken
`timescale 1ns/1ps
module etds_fcs_check (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // Byte stream
   input wire logic restart,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // Result
   output logic fcs_ok
);
   logic [31:0] crc_reg;
   logic [31:0] crc_next;

   ////////////////////////////////////////////////////////////////////////////
   // One byte through the reflected polynomial
   always_comb begin
      crc_next = crc_reg;
      for (int i = 0; i < 8; i++) begin
         if (crc_next[0] ^ byte_data[i]) begin
            crc_next = (crc_next >> 1) ^ etds_pkg::CRC_POLY;
         end else begin
            crc_next = crc_next >> 1;
         end
      end
   end

   // Restart wins over a byte so a retry starts clean
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         crc_reg <= etds_pkg::CRC_INIT;
      end else if (ce) begin
         if (restart) begin
            crc_reg <= etds_pkg::CRC_INIT;
         end else if (byte_valid) begin
            crc_reg <= crc_next;
         end
      end
   end

   assign fcs_ok = (crc_reg == etds_pkg::CRC_RESIDUE);
endmodule : etds_fcs_check

// *** verilog/etds_defer_timer.sv ***
// Purpose: measures deferral time of one frame attempt
// Assumes: deferring is a level from the transmit engine
// Notes: the count saturates so a long wait never wraps back to clear
`timescale 1ns/1ps
module etds_defer_timer #(
   parameter int LIMIT_100 = etds_pkg::XS_DEFER_CYC_100,
   parameter int LIMIT_10 = etds_pkg::XS_DEFER_CYC_10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // Control
   input wire logic restart,
   input wire logic deferring,
   input wire logic speed_100,
   // Result
   output logic excess
);
   logic [17:0] cnt_reg;
   logic [17:0] limit;

   assign limit = speed_100 ? 18'(LIMIT_100) : 18'(LIMIT_10);

   ////////////////////////////////////////////////////////////////////////////
   // Count deferring cycles, hold at the top
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 18'h00000;
      end else if (ce) begin
         if (restart) begin
            cnt_reg <= 18'h00000;
         end else if (deferring && cnt_reg != 18'h3ffff) begin
            cnt_reg <= cnt_reg + 18'h00001;
         end
      end
   end

   assign excess = (cnt_reg > limit);
endmodule : etds_defer_timer

// *** verification/etds_top_asserts.sv ***
// Purpose: concurrent checks on the descriptor status ports
// Assumes: ce is held high by the bench
// Notes: seen_bp remembers back pressure inside the current attempt
`timescale 1ns/1ps
module etds_top_checker #(
   parameter int XS_LIMIT_100 = etds_pkg::XS_DEFER_CYC_100,
   parameter int XS_LIMIT_10 = etds_pkg::XS_DEFER_CYC_10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // Watched ports
   input etds_pkg::etds_tx_ev_t tx_ev,
   input wire logic desc_wr_valid,
   input etds_pkg::etds_status_t desc_wr_word,
   input wire logic descriptor_owner_flag,
   input wire logic tx_abandon,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic seen_bp;
   ////////////////////////////////////////////////////////////////////////////
   // Back pressure since the attempt began; only read at write-back
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         seen_bp <= 1'b0;
      end else if (ce && tx_ev.start && !descriptor_owner_flag) begin
         seen_bp <= 1'b0;
      end else if (ce && descriptor_owner_flag && tx_ev.backpressure) begin
         seen_bp <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Write-back timing and ownership
   a_wb_after_finish: assert property (ce && tx_ev.finish && descriptor_owner_flag
      |=> desc_wr_valid)
      else $error("no write-back after finish");
   a_owner_handback: assert property (desc_wr_valid
      |-> !desc_wr_word.descriptor_owner_flag && !descriptor_owner_flag)
      else $error("descriptor not handed back");
   a_wb_single: assert property (ce && desc_wr_valid |=> !desc_wr_valid)
      else $error("write-back longer than one cycle");
   a_owner_take: assert property (ce && tx_ev.start && !descriptor_owner_flag
      && !desc_wr_valid |=> descriptor_owner_flag)
      else $error("start did not take the descriptor");
   a_word_held: assert property (ce && !$rose(desc_wr_valid) |-> $stable(desc_wr_word))
      else $error("status word changed outside write-back");
   // Abandon outcomes, back pressure flag and covers
   a_abandon_report: assert property (ce && tx_abandon
      |=> desc_wr_valid && desc_wr_word.frame_abandoned_flag)
      else $error("abandon not reported");
   a_retry_abandon: assert property (desc_wr_valid && desc_wr_word.retry_limit_flag
      |-> desc_wr_word.frame_abandoned_flag && desc_wr_word.collision_tally != 4'h0)
      else $error("retry limit without abandon");
   a_late_abandon: assert property (desc_wr_valid && desc_wr_word.late_collision_flag
      |-> desc_wr_word.frame_abandoned_flag)
      else $error("late collision not abandoned");
   a_bp_flag: assert property (desc_wr_valid && seen_bp
      |-> desc_wr_word.backpressure_applied_flag)
      else $error("back pressure not reported");
   c_clean: cover property (desc_wr_valid && !desc_wr_word.frame_abandoned_flag);
   c_abandon: cover property (tx_abandon);
   c_irq: cover property (irq);
endmodule : etds_top_checker

bind etds_top etds_top_checker #(.XS_LIMIT_100(XS_LIMIT_100), .XS_LIMIT_10(XS_LIMIT_10)) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .tx_ev(tx_ev), .desc_wr_valid(desc_wr_valid),
   .desc_wr_word(desc_wr_word), .descriptor_owner_flag(descriptor_owner_flag),
   .tx_abandon(tx_abandon), .irq(irq));

// *** verification/etds_tx_engine_model.sv ***
// Purpose: transmit engine model feeding per-cycle events
// Assumes: tx_abandon answers in the cycle of the event
// Notes: retries resend from byte 0, as a real engine does
`timescale 1ns/1ps
module etds_tx_engine_model (
   // Clock
   input wire logic mclk,
   // Event stream
   output etds_pkg::etds_tx_ev_t tx_ev,
   // Abandon answer
   input wire logic tx_abandon
);
   logic ab;
   initial tx_ev = '0;
   // One cycle of events; called just after an edge so steps run back to back
   task automatic step(input etds_pkg::etds_tx_ev_t ev);
      tx_ev <= ev;
      @(posedge mclk);
      ab = tx_abandon;
   endtask : step
   // Whole attempt: collisions at cpos, optional underrun, then the frame
   task automatic send(input int len, input logic [15:0] tl, input int ncol, input int cpos,
                       input bit urun, input bit bp, input int dfr);
      etds_pkg::etds_tx_ev_t ev;
      int n;
      ev = '0;
      @(posedge mclk);
      ev.start = 1'b1;
      step(ev);
      ev = '0;
      ev.deferring = 1'b1;
      repeat (dfr) step(ev);
      ab = 1'b0;
      for (int p = 0; p <= ncol + int'(urun) && !ab; p++) begin
         n = (p < ncol) ? cpos : ((p < ncol + int'(urun)) ? 10 : len);
         for (int i = 0; i < n; i++) begin
            ev = '0;
            ev.byte_valid = 1'b1;
            ev.backpressure = bp;
            ev.byte_data = (i == 12) ? tl[15:8] : ((i == 13) ? tl[7:0] : 8'(i));
            step(ev);
         end
         ev = '0;
         ev.collision = (p < ncol);
         ev.underrun = (p >= ncol) && (p < ncol + int'(urun));
         ev.finish = (p == ncol + int'(urun));
         step(ev);
      end
      // Gap of more than two cycles before the next start
      tx_ev <= '0;
      repeat (3) @(posedge mclk);
   endtask : send
endmodule : etds_tx_engine_model

// *** verification/eth_tx_descriptor_status_tb_top.sv ***
// Purpose: self-checking bench for the descriptor status block
// Assumes: deferral limits shortened to 20 and 40 cycles
// Notes: a monitor keeps the last written word and counts write-backs
`timescale 1ns/1ps
module eth_tx_descriptor_status_tb_top;
   typedef struct {int len; logic [15:0] tl; int ncol; int cpos; bit urun; bit bp; int dfr;
                   bit spd; logic [15:0] exp;} etds_row_t;
   logic mclk, sys_rst, speed_100, reg_wr, reg_rd, desc_wr_valid, descriptor_owner_flag;
   logic tx_abandon, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, got, d;
   etds_pkg::etds_tx_ev_t tx_ev;
   etds_pkg::etds_status_t desc_wr_word;
   int num_errors, n_compared, n_wb;
   logic [3:0] ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
   logic [15:0] rv [8] = '{16'h0001, 16'h0600, 16'h0037, 16'h000f, 16'h0, 16'h0, 16'h0, 16'h0};
   etds_row_t rows [13] = '{
      '{64, 16'h0800, 0, 0, 0, 0, 0, 1, 16'h0000}, '{64, 16'h002e, 0, 0, 0, 0, 0, 1, 16'h0000},
      '{64, 16'h05ee, 0, 0, 0, 0, 0, 1, 16'h0400}, '{64, 16'h05ef, 0, 0, 0, 0, 0, 1, 16'h0c00},
      '{64, 16'h0600, 0, 0, 0, 0, 0, 1, 16'h0000}, '{1536, 16'h0800, 0, 0, 0, 0, 0, 1, 16'h0000},
      '{1537, 16'h0800, 0, 0, 0, 0, 0, 1, 16'h1000}, '{64, 16'h0800, 0, 0, 0, 1, 0, 1, 16'h2000},
      '{64, 16'h0800, 0, 0, 0, 0, 30, 1, 16'h0180}, '{64, 16'h0800, 0, 0, 0, 0, 30, 0, 16'h0100},
      '{64, 16'h0800, 2, 2, 0, 0, 0, 1, 16'h0002}, '{64, 16'h0800, 1, 55, 0, 0, 0, 1, 16'h0001},
      '{64, 16'h0800, 1, 60, 0, 0, 0, 1, 16'h4021}};
   etds_top #(.XS_LIMIT_100(20), .XS_LIMIT_10(40)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
      .ce(1'b1), .speed_100(speed_100), .tx_ev(tx_ev), .desc_wr_valid(desc_wr_valid),
      .desc_wr_word(desc_wr_word), .descriptor_owner_flag(descriptor_owner_flag),
      .tx_abandon(tx_abandon), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   etds_tx_engine_model u_eng (.mclk(mclk), .tx_ev(tx_ev), .tx_abandon(tx_abandon));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and write-back monitor
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (desc_wr_valid === 1'b1) begin
         got = desc_wr_word;
         n_wb++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the read edge
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic frame(input etds_row_t r);
      int w;
      w = n_wb;
      @(posedge mclk);
      speed_100 <= r.spd;
      u_eng.send(r.len, r.tl, r.ncol, r.cpos, r.urun, r.bp, r.dfr);
      chk(got, r.exp);
      chk(16'(n_wb - w), 16'h0001);
   endtask : frame
   task automatic report_and_stop;
      $display("errors %0d compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {sys_rst, speed_100} = 2'b11;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {num_errors, n_compared, n_wb} = '0;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk({12'h0, irq, desc_wr_valid, descriptor_owner_flag, tx_abandon}, 16'h0);
      for (int i = 0; i < 8; i++) begin
         rd(ra[i]);
         chk(d, rv[i]);
      end
      foreach (rows[i]) frame(rows[i]);
      frame('{64, 16'h0800, 0, 0, 1, 0, 0, 1, 16'h4040});
      rd(4'h4);
      chk(d, 16'h4040);
      // Interrupt: masked, unmasked, cleared by reading status
      chk({15'h0, irq}, 16'h0);
      wr(4'h6, 16'h0007);
      #1 chk({15'h0, irq}, 16'h0001);
      rd(4'h5);
      chk(d, 16'h0007);
      chk({15'h0, irq}, 16'h0);
      wr(4'h3, 16'h0002);
      frame('{64, 16'h0800, 3, 2, 0, 0, 0, 1, 16'h4013});
      wr(4'h0, 16'h0002);
      frame('{64, 16'h0800, 0, 0, 1, 0, 0, 1, 16'h0240});
      wr(4'hf, 16'hffff);
      rd(4'hf);
      chk(d, 16'h0);
      report_and_stop();
   end
   // Watchdog well beyond the expected run
   initial begin
      #400000;
      num_errors++;
      report_and_stop();
   end
endmodule : eth_tx_descriptor_status_tb_top
